// >>> dv/chd_host.sv
// Host model: an AXI4-Lite master that runs one transfer at a time.
// Assumes the slave shares aclk; a transfer left unanswered for 64 clocks is reported as a timeout.
`timescale 1ns/1ps
module chd_host (
    // Clock and slave answers
    input wire logic aclk,
    input wire logic awready, wready, bvalid, arready, rvalid,
    input wire logic [1:0] bresp,
    input wire logic [31:0] rdata,
    // Master requests
    output logic [7:0] awaddr, araddr,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic awvalid, wvalid, bready, arvalid, rready
);
    initial {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    // A taken payload is inverted, so a slave that samples it late reads garbage.
    task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output bit to);
        to = 1'b1;
        @(posedge aclk);
        if (wr) {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'b111};
        else {araddr, arvalid, rready} <= {a, 2'b11};
        for (int n = 0; n < 64 && to; n++) begin
            @(posedge aclk);
            if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~awaddr};
            if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~wdata};
            if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~araddr};
            if (wr ? bvalid : rvalid) begin
                q = wr ? {30'h0, bresp} : rdata;
                {bready, rready} <= 2'b00;
                to = 1'b0;
            end
        end
    endtask : xfer
endmodule : chd_host

// >>> dv/tb.sv
// Testbench: the host model drives the decoder; results are checked at the ports.
// Assumes a blink half period of 8 clocks so a blink fits a short run.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
    logic aclk = 1'b0;
    logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic display_on, blink_fill, bus_width_sel, two_lines;
    logic [1:0] bresp, rresp, luminance;
    logic [3:0] wstrb;
    logic [5:0] shift_offset;
    logic [6:0] cursor_pos, a;
    logic [7:0] awaddr, araddr, cursor_row_mask, d;
    logic [31:0] wdata, rdata, q;
    int failures = 0;
    int num_checks = 0;
    chd_top #(.BLINK_HALF_CYC(8)) u_chd_top (.*);
    chd_host u_chd_host (.*);
    initial forever #20 aclk = ~aclk;
    function automatic logic [6:0] step(logic [6:0] v);
        return (v == 7'h27) ? 7'h40 : (v == 7'h67) ? 7'h00 : v + 7'h01;
    endfunction : step
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic acc(input bit wr, input logic [7:0] ad, input logic [31:0] v);
        bit to;
        u_chd_host.xfer(wr, ad, v, q, to);
        if (to) begin
            failures++;
            tally_and_finish;
        end
        #1;
    endtask : acc
    initial begin
        aresetn = 1'b0;
        void'($urandom(56127));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        acc(0, 8'h08, 0);
        `CHK({rresp, q, display_on, cursor_row_mask, blink_fill, shift_offset}, {2'b00, 32'h68, 16'h0000})
        for (int i = 0; i < 5; i++) begin
            a = (i == 0) ? 7'h27 : (i == 1) ? 7'h67 : {1'($urandom), 6'h0} + 7'($urandom % 40);
            d = 8'($urandom);
            acc(1, 8'h00, {25'h1, a});
            acc(1, 8'h04, {24'h0, d});
            acc(0, 8'h00, 0);
            `CHK(q, {25'h0, step(a)})
            acc(1, 8'h00, {25'h1, a});
            acc(0, 8'h04, 0);
            `CHK(q, {24'h0, d})
            `CHK(cursor_pos, step(a))
        end
        acc(1, 8'h00, 32'h04);
        acc(1, 8'h00, 32'h80);
        acc(1, 8'h04, 32'h41);
        `CHK(cursor_pos, 7'h67)
        acc(1, 8'h00, 32'h40);
        acc(1, 8'h04, 32'h15);
        acc(0, 8'h08, 0);
        `CHK({q[10], cursor_pos}, {1'b1, 7'h3f})
        acc(1, 8'h00, 32'h14);
        acc(0, 8'h08, 0);
        `CHK({q[10], cursor_pos}, {1'b0, step(7'h3f)})
        acc(1, 8'h00, 32'h01);
        acc(0, 8'h08, 0);
        `CHK({q, cursor_pos}, {32'h68, 7'h00})
        acc(1, 8'h00, 32'h07);
        acc(1, 8'h04, 32'h33);
        `CHK(shift_offset, 6'h01)
        acc(0, 8'h04, 0);
        `CHK({q, shift_offset}, {32'h20, 6'h01})
        acc(1, 8'h00, 32'h02);
        `CHK({shift_offset, cursor_pos}, 13'h0)
        acc(1, 8'h00, 32'h18);
        `CHK({shift_offset, cursor_pos}, {6'h01, 7'h67})
        for (int l = 0; l < 4; l++) begin
            acc(1, 8'h00, 32'h28 | l);
            `CHK({bus_width_sel, two_lines, luminance}, {2'b01, 2'(l)})
        end
        acc(1, 8'h00, 32'h0e);
        `CHK({display_on, cursor_row_mask, cursor_pos}, {1'b1, 8'h80, 7'h67})
        acc(1, 8'h00, 32'h0f);
        d = 0;
        repeat (32) @(posedge aclk) d += 8'(blink_fill);
        `CHK(d, 8'd16)
        acc(1, 8'h0c, 0);
        `CHK(q, 32'h2)
        acc(0, 8'h0c, 0);
        `CHK({rresp, q}, {2'b10, 32'h0})
        tally_and_finish;
    end
endmodule : tb

// >>> rtl/chd_defines.svh
// Constants of the character display instruction decoder: offsets, field positions, reset values, timing.
// Assumes it is included by bare name from files that need them; definitions only.
//
// Functional notes
// - Clear fills display RAM with 20H, counter 00H, unshifts, forces increment, glyph untouched.
// - Home sets counter to display 00H and unshifts; RAM contents are kept.
// - Direction bit 0 decrements, 1 increments; shift right or left after display writes.
// - Automatic shift only after display RAM writes, never after reads or glyph access.
// - Display control stores display on, cursor on and blink; RAM and counter unchanged.
// - Cursor shows on the eighth pixel row of the cell at the counter.
// - Blink alternates cursor cell with all-on cell at about 1Hz, 50% duty.
// - Cursor/display shift steps counter by R/L; with S/C set, shifts display too.
// - After a cursor/display shift the counter addresses display RAM.
// - Function set bus width bit: 0 selects 4-bit, 1 selects 8-bit transfers.
// - Luminance field 00,01,10,11 selects 100%, 75%, 50%, 25%.
// - Glyph address set loads low six bits and routes data accesses to glyph RAM.
// - Display address set loads low seven bits and routes data accesses to display RAM.
// - Instruction read returns counter on bits 6-0 and busy flag 0, no side effects.
// - Instructions and data are accepted back to back with no busy period.
// - Data write stores the byte at the counter in the RAM chosen last.
// - After each data write the counter steps; after display RAM writes the display shifts if enabled.
// - Data read returns the byte at the counter, then steps the counter.
// - Display counter steps 27H-40H and 67H-00H; glyph counter wraps 3FH-00H.
// - Reset blanks display RAM, counter 00H, increment, display, cursor, blink and shift off, 8-bit, two lines, 100%.
`ifndef CHD_DEFINES_SVH
`define CHD_DEFINES_SVH

`define CHD_OFF_INSTR 8'h00
`define CHD_OFF_DATA 8'h04
`define CHD_OFF_STATUS 8'h08

`define CHD_RESP_OKAY 2'b00
`define CHD_RESP_SLVERR 2'b10

`define CHD_SPACE 8'h20
`define CHD_COUNTER_HOME 7'h00
`define CHD_DISP_L1_END 7'h27
`define CHD_DISP_L2_BEG 7'h40
`define CHD_DISP_L2_END 7'h67
`define CHD_COL_LAST 6'h27
`define CHD_CURSOR_ROW_MASK 8'h80

`define CHD_RST_INC 1'b1
`define CHD_RST_BUS8 1'b1
`define CHD_RST_LINES2 1'b1
`define CHD_RST_LUM 2'b00

`define CHD_ST_DISP 0
`define CHD_ST_CURSOR 1
`define CHD_ST_BLINK 2
`define CHD_ST_INC 3
`define CHD_ST_SHIFT 4
`define CHD_ST_BUS8 5
`define CHD_ST_LINES2 6
`define CHD_ST_LUM_LO 8
`define CHD_ST_LUM_HI 9
`define CHD_ST_GLYPH 10
`define CHD_ST_OFF_LO 16
`define CHD_ST_OFF_HI 21

`define CHD_CLK_HZ 25000000
`define CHD_BLINK_HALF_MS 500
`define CHD_BLINK_HALF_CYC ((`CHD_CLK_HZ / 1000) * `CHD_BLINK_HALF_MS)

`endif

// >>> rtl/chd_mem.sv
// Byte memory with registered read data and an instant blank-all.
// Assumes one clock; blanking marks every entry as a space so no fill cycles are needed.
`timescale 1ns/1ps
`include "chd_defines.svh"
module chd_mem
    import chd_pkg::*;
#(
    parameter int DEPTH = 128,
    parameter bit BLANKABLE = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Access port
    chd_mem_if.ram port
);
    localparam int AW = $clog2(DEPTH);

    logic [7:0] mem_q [0:DEPTH-1];
    logic [DEPTH-1:0] blank_reg;
    logic [7:0] rdata_reg;
    wire logic [AW-1:0] idx = port.addr[AW-1:0];

    always_ff @(posedge aclk) begin
        if (port.we) begin
            mem_q[idx] <= port.wdata;
        end
    end

    // A blanked entry reads as a space until written again.
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_blank
            wire logic hit = port.we && (idx == AW'(i));
            always_ff @(posedge aclk) begin
                if (!aresetn || port.blank_all) begin
                    blank_reg[i] <= BLANKABLE;
                end else if (hit) begin
                    blank_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_reg <= 8'h00;
        end else if (port.re) begin
            rdata_reg <= blank_reg[idx] ? `CHD_SPACE : mem_q[idx];
        end
    end

    assign port.rdata = rdata_reg;
endmodule : chd_mem

// >>> rtl/chd_mem_if.sv
// Access port between the decoder and one of its character memories.
// Assumes one controller and one memory per instance, both on the same clock.
`timescale 1ns/1ps
interface chd_mem_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic blank_all;
    logic [7:0] rdata;

    modport ctrl (output addr, output wdata, output we, output re, output blank_all, input rdata);
    modport ram (input addr, input wdata, input we, input re, input blank_all, output rdata);
endinterface : chd_mem_if

// >>> rtl/chd_pkg.sv
// Types shared by the character display instruction decoder.
// Assumes the constants header is included where figures are needed.
package chd_pkg;

    typedef enum logic [1:0] {
        CHD_RD_IDLE = 2'b00,
        CHD_RD_FETCH = 2'b01,
        CHD_RD_RESP = 2'b11
    } chd_rd_state_t;

    typedef enum logic [3:0] {
        CHD_OP_NONE,
        CHD_OP_CLEAR,
        CHD_OP_HOME,
        CHD_OP_ENTRY,
        CHD_OP_CTRL,
        CHD_OP_CSHIFT,
        CHD_OP_FSET,
        CHD_OP_GSET,
        CHD_OP_DSET
    } chd_op_t;

endpackage : chd_pkg

// >>> rtl/chd_top.sv
// Character display instruction decoder behind an AXI4-Lite slave.
// Assumes one clock at 25 MHz and a synchronous active-low reset; the scanner reads the outputs.
`timescale 1ns/1ps
`include "chd_defines.svh"
module chd_top
    import chd_pkg::*;
#(
    parameter int BLINK_HALF_CYC = `CHD_BLINK_HALF_CYC
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address and data
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Display state towards the scanner
    output logic display_on,
    output logic [6:0] cursor_pos,
    output logic [7:0] cursor_row_mask,
    output logic blink_fill,
    output logic [5:0] shift_offset,
    output logic [1:0] luminance,
    output logic bus_width_sel,
    output logic two_lines
);
    chd_mem_if disp_bus ();
    chd_mem_if glyph_bus ();

    chd_mem #(.DEPTH(128), .BLANKABLE(1'b1)) u_display_ram (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(disp_bus)
    );
    chd_mem #(.DEPTH(64), .BLANKABLE(1'b0)) u_glyph_ram (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(glyph_bus)
    );

    // Write channel holding registers.
    logic aw_full_reg, w_full_reg, bvalid_reg;
    logic [7:0] aw_addr_reg;
    logic [7:0] w_byte_reg;
    logic w_lane0_reg;
    logic [1:0] bresp_reg;
    // Read channel.
    chd_rd_state_t rd_state_reg;
    logic [7:0] rd_addr_reg;
    logic rd_glyph_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    // Decoder state.
    logic [6:0] address_counter_reg, address_counter_next;
    logic glyph_mode_reg, glyph_mode_next;
    logic [5:0] offset_reg, offset_next;
    logic inc_reg, inc_next, shift_en_reg, shift_en_next;
    logic disp_on_reg, disp_on_next, cursor_on_reg, cursor_on_next, blink_reg, blink_next;
    logic bus8_reg, bus8_next, lines2_reg, lines2_next;
    logic [1:0] lum_reg, lum_next;
    logic [23:0] blink_cnt_reg;
    logic blink_phase_reg, blink_fill_reg;
    logic [7:0] cursor_mask_reg;

    function automatic logic [6:0] chd_step(input logic [6:0] a, input logic up, input logic glyph);
        logic [6:0] r;
        r = a;
        if (glyph) begin
            r = {1'b0, up ? 6'(a[5:0] + 6'h01) : 6'(a[5:0] - 6'h01)};
        end else if (up) begin
            r = (a == `CHD_DISP_L1_END) ? `CHD_DISP_L2_BEG :
                (a == `CHD_DISP_L2_END) ? `CHD_COUNTER_HOME : 7'(a + 7'h01);
        end else begin
            r = (a == `CHD_DISP_L2_BEG) ? `CHD_DISP_L1_END :
                (a == `CHD_COUNTER_HOME) ? `CHD_DISP_L2_END : 7'(a - 7'h01);
        end
        return r;
    endfunction : chd_step

    // Shifting left moves later addresses into view, so the start column advances.
    function automatic logic [5:0] chd_shift(input logic [5:0] o, input logic left);
        logic [5:0] r;
        if (left) begin
            r = (o == `CHD_COL_LAST) ? 6'h00 : 6'(o + 6'h01);
        end else begin
            r = (o == 6'h00) ? `CHD_COL_LAST : 6'(o - 6'h01);
        end
        return r;
    endfunction : chd_shift

    // Writes run in one cycle, so a read is only taken when no write executes beside it.
    wire logic wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    wire logic wr_mapped = (aw_addr_reg == `CHD_OFF_INSTR) || (aw_addr_reg == `CHD_OFF_DATA) ||
                           (aw_addr_reg == `CHD_OFF_STATUS);
    wire logic instr_go = wr_go && w_lane0_reg && (aw_addr_reg == `CHD_OFF_INSTR);
    wire logic data_wr_go = wr_go && w_lane0_reg && (aw_addr_reg == `CHD_OFF_DATA);
    wire logic ar_take = arvalid && arready;
    wire logic rd_mapped = (araddr == `CHD_OFF_INSTR) || (araddr == `CHD_OFF_DATA) ||
                           (araddr == `CHD_OFF_STATUS);
    wire logic data_rd_go = ar_take && (araddr == `CHD_OFF_DATA);

    wire chd_op_t op = w_byte_reg[7] ? CHD_OP_DSET :
                       w_byte_reg[6] ? CHD_OP_GSET :
                       w_byte_reg[5] ? CHD_OP_FSET :
                       w_byte_reg[4] ? CHD_OP_CSHIFT :
                       w_byte_reg[3] ? CHD_OP_CTRL :
                       w_byte_reg[2] ? CHD_OP_ENTRY :
                       w_byte_reg[1] ? CHD_OP_HOME :
                       w_byte_reg[0] ? CHD_OP_CLEAR : CHD_OP_NONE;
    wire logic clear_go = instr_go && (op == CHD_OP_CLEAR);

    wire logic [31:0] status_word = {10'h000, offset_reg, 5'h00, glyph_mode_reg, lum_reg, 1'b0, lines2_reg,
                                     bus8_reg, shift_en_reg, inc_reg, blink_reg, cursor_on_reg, disp_on_reg};
    wire logic [31:0] instr_word = {24'h000000, 1'b0, address_counter_reg};

    // Memory ports: the glyph mode flag, set by glyph address set and cleared by display address set, clear, home and cursor shift, picks the RAM.
    assign disp_bus.addr = address_counter_reg;
    assign disp_bus.wdata = w_byte_reg;
    assign disp_bus.we = data_wr_go && !glyph_mode_reg;
    assign disp_bus.re = data_rd_go && !glyph_mode_reg;
    assign disp_bus.blank_all = clear_go;
    assign glyph_bus.addr = {1'b0, address_counter_reg[5:0]};
    assign glyph_bus.wdata = w_byte_reg;
    assign glyph_bus.we = data_wr_go && glyph_mode_reg;
    assign glyph_bus.re = data_rd_go && glyph_mode_reg;
    assign glyph_bus.blank_all = 1'b0;

    always_comb begin
        address_counter_next = address_counter_reg;
        glyph_mode_next = glyph_mode_reg;
        offset_next = offset_reg;
        inc_next = inc_reg;
        shift_en_next = shift_en_reg;
        disp_on_next = disp_on_reg;
        cursor_on_next = cursor_on_reg;
        blink_next = blink_reg;
        bus8_next = bus8_reg;
        lines2_next = lines2_reg;
        lum_next = lum_reg;
        if (instr_go) begin
            unique case (op)
                CHD_OP_CLEAR: begin
                    address_counter_next = `CHD_COUNTER_HOME;
                    glyph_mode_next = 1'b0;
                    offset_next = 6'h00;
                    inc_next = 1'b1;
                end
                CHD_OP_HOME: begin
                    address_counter_next = `CHD_COUNTER_HOME;
                    glyph_mode_next = 1'b0;
                    offset_next = 6'h00;
                end
                CHD_OP_ENTRY: begin
                    inc_next = w_byte_reg[1];
                    shift_en_next = w_byte_reg[0];
                end
                CHD_OP_CTRL: begin
                    disp_on_next = w_byte_reg[2];
                    cursor_on_next = w_byte_reg[1];
                    blink_next = w_byte_reg[0];
                end
                CHD_OP_CSHIFT: begin
                    address_counter_next = chd_step(address_counter_reg, w_byte_reg[2], 1'b0);
                    glyph_mode_next = 1'b0;
                    if (w_byte_reg[3]) begin
                        offset_next = chd_shift(offset_reg, !w_byte_reg[2]);
                    end
                end
                CHD_OP_FSET: begin
                    bus8_next = w_byte_reg[4];
                    lines2_next = w_byte_reg[3];
                    lum_next = w_byte_reg[1:0];
                end
                CHD_OP_GSET: begin
                    address_counter_next = {1'b0, w_byte_reg[5:0]};
                    glyph_mode_next = 1'b1;
                end
                CHD_OP_DSET: begin
                    address_counter_next = w_byte_reg[6:0];
                    glyph_mode_next = 1'b0;
                end
                CHD_OP_NONE: begin
                end
            endcase
        end else if (data_wr_go) begin
            address_counter_next = chd_step(address_counter_reg, inc_reg, glyph_mode_reg);
            if (shift_en_reg && !glyph_mode_reg) begin
                offset_next = chd_shift(offset_reg, inc_reg);
            end
        end else if (data_rd_go) begin
            address_counter_next = chd_step(address_counter_reg, inc_reg, glyph_mode_reg);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            address_counter_reg <= `CHD_COUNTER_HOME;
            glyph_mode_reg <= 1'b0;
            offset_reg <= 6'h00;
            inc_reg <= `CHD_RST_INC;
            shift_en_reg <= 1'b0;
            disp_on_reg <= 1'b0;
            cursor_on_reg <= 1'b0;
            blink_reg <= 1'b0;
            bus8_reg <= `CHD_RST_BUS8;
            lines2_reg <= `CHD_RST_LINES2;
            lum_reg <= `CHD_RST_LUM;
        end else begin
            address_counter_reg <= address_counter_next;
            glyph_mode_reg <= glyph_mode_next;
            offset_reg <= offset_next;
            inc_reg <= inc_next;
            shift_en_reg <= shift_en_next;
            disp_on_reg <= disp_on_next;
            cursor_on_reg <= cursor_on_next;
            blink_reg <= blink_next;
            bus8_reg <= bus8_next;
            lines2_reg <= lines2_next;
            lum_reg <= lum_next;
        end
    end

    // Address and data are taken in either order and held until the response is accepted.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_byte_reg <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end else if (bvalid_reg && bready) begin
                aw_full_reg <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_reg <= 1'b1;
                w_byte_reg <= wdata[7:0];
                w_lane0_reg <= wstrb[0];
            end else if (bvalid_reg && bready) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `CHD_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? `CHD_RESP_OKAY : `CHD_RESP_SLVERR;
        end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Register values are captured at the take; RAM data one cycle later from the memory.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_reg <= CHD_RD_IDLE;
            rd_addr_reg <= 8'h00;
            rd_glyph_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `CHD_RESP_OKAY;
        end else begin
            unique case (rd_state_reg)
                CHD_RD_IDLE: begin
                    if (ar_take) begin
                        rd_state_reg <= CHD_RD_FETCH;
                        rd_addr_reg <= araddr;
                        rd_glyph_reg <= glyph_mode_reg;
                        rresp_reg <= rd_mapped ? `CHD_RESP_OKAY : `CHD_RESP_SLVERR;
                        rdata_reg <= (araddr == `CHD_OFF_INSTR) ? instr_word :
                                     (araddr == `CHD_OFF_STATUS) ? status_word : 32'h00000000;
                    end
                end
                CHD_RD_FETCH: begin
                    rd_state_reg <= CHD_RD_RESP;
                    if (rd_addr_reg == `CHD_OFF_DATA) begin
                        rdata_reg <= {24'h000000, rd_glyph_reg ? glyph_bus.rdata : disp_bus.rdata};
                    end
                end
                CHD_RD_RESP: begin
                    if (rready) begin
                        rd_state_reg <= CHD_RD_IDLE;
                    end
                end
                default: begin
                    rd_state_reg <= CHD_RD_IDLE;
                end
            endcase
        end
    end

    // The blink phase is a free-running square wave that toggles every half second.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt_reg <= 24'h000000;
            blink_phase_reg <= 1'b0;
            blink_fill_reg <= 1'b0;
            cursor_mask_reg <= 8'h00;
        end else begin
            if (blink_cnt_reg == 24'(BLINK_HALF_CYC - 1)) begin
                blink_cnt_reg <= 24'h000000;
                blink_phase_reg <= !blink_phase_reg;
            end else begin
                blink_cnt_reg <= 24'(blink_cnt_reg + 24'h000001);
            end
            blink_fill_reg <= blink_reg && blink_phase_reg && disp_on_reg && !glyph_mode_reg;
            cursor_mask_reg <= (cursor_on_reg && disp_on_reg && !glyph_mode_reg) ?
                               `CHD_CURSOR_ROW_MASK : 8'h00;
        end
    end

    assign awready = !aw_full_reg;
    assign wready = !w_full_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = (rd_state_reg == CHD_RD_IDLE) && !wr_go;
    assign rvalid = (rd_state_reg == CHD_RD_RESP);
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign display_on = disp_on_reg;
    assign cursor_pos = address_counter_reg;
    assign cursor_row_mask = cursor_mask_reg;
    assign blink_fill = blink_fill_reg;
    assign shift_offset = offset_reg;
    assign luminance = lum_reg;
    assign bus_width_sel = bus8_reg;
    assign two_lines = lines2_reg;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_both;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_exec;
        wr_go;
    endsequence

    AST_CLEAR: assert property (clear_go
        |=> address_counter_reg == 7'h00 && offset_reg == 6'h00 && inc_reg && !glyph_mode_reg)
        else $error("clear did not home, unshift and set increment");
    AST_HOME: assert property (instr_go && op == CHD_OP_HOME
        |=> address_counter_reg == 7'h00 && offset_reg == 6'h00)
        else $error("home did not reset counter and shift");
    AST_NO_BUSY: assert property (s_wr_both |=> s_exec ##1 bvalid)
        else $error("write not answered two cycles after both channels taken");
    AST_INSTR_READ: assert property (rvalid && rd_addr_reg == `CHD_OFF_INSTR |-> rdata[31:7] == 25'h0000000)
        else $error("instruction read shows a busy flag or stray bits");
    AST_READ_NO_SHIFT: assert property (data_rd_go |=> $stable(offset_reg))
        else $error("display shifted after a data read");
    AST_WRAP_UP: assert property (data_wr_go && !glyph_mode_reg && inc_reg && address_counter_reg == 7'h27
        |=> address_counter_reg == 7'h40)
        else $error("display counter did not wrap 27H to 40H");
    AST_CSHIFT_MODE: assert property (instr_go && op == CHD_OP_CSHIFT |=> !glyph_mode_reg)
        else $error("cursor shift left the counter in glyph mode");
    AST_GLYPH_SET: assert property (instr_go && op == CHD_OP_GSET
        |=> glyph_mode_reg && address_counter_reg == {1'b0, $past(w_byte_reg[5:0])})
        else $error("glyph address set not loaded");
    AST_DISP_SET: assert property (instr_go && op == CHD_OP_DSET
        |=> !glyph_mode_reg && address_counter_reg == $past(w_byte_reg[6:0]))
        else $error("display address set not loaded");
    AST_FSET: assert property (instr_go && op == CHD_OP_FSET
        |=> bus8_reg == $past(w_byte_reg[4]) && lum_reg == $past(w_byte_reg[1:0]))
        else $error("function set fields not stored");
    AST_CURSOR_ROW: assert property (cursor_on_reg && disp_on_reg && !glyph_mode_reg
        ##1 cursor_on_reg |-> cursor_row_mask == 8'h80)
        else $error("cursor not drawn on bottom row");
endmodule : chd_top
